//--- include/atp_consts.svh
// Register offsets, field positions and reset values of the auxiliary timer pair
`ifndef ATP_CONSTS_SVH
`define ATP_CONSTS_SVH

`define ATP_ADDR_W        4
`define ATP_DATA_W        16
`define ATP_ADDR_CTL_A    4'h0
`define ATP_ADDR_CTL_B    4'h1
`define ATP_ADDR_CNT_A    4'h2
`define ATP_ADDR_CNT_B    4'h3
`define ATP_ADDR_STATUS   4'h4

`define ATP_CTL_W         10
`define ATP_CTL_SEL_LSB   0
`define ATP_CTL_SEL_MSB   2
`define ATP_CTL_MODE_LSB  3
`define ATP_CTL_MODE_MSB  5
`define ATP_CTL_RUN       6
`define ATP_CTL_UD        7
`define ATP_CTL_UDE       8
`define ATP_CTL_RC        9
`define ATP_CTL_RESET     10'h000
`define ATP_CNT_RESET     16'h0000

`define ATP_PRE_W         10
`define ATP_PRE_BASE      3
`define ATP_PRE_STEPS     8

`endif

//--- include/atp_pkg.sv
// Types shared by the auxiliary timer pair
package atp_pkg;
	typedef enum logic [2:0] {
		ATP_MODE_TIMER    = 3'h0,
		ATP_MODE_COUNTER  = 3'h1,
		ATP_MODE_GATE_LOW = 3'h2,
		ATP_MODE_GATE_HI  = 3'h3,
		ATP_MODE_RELOAD   = 3'h4
	} atp_mode_t;
endpackage

//--- core/atp_trig_sel.sv
// Count and reload trigger selection from the 3-bit input-select field
`timescale 1ns/1ps
module atp_trig_sel (
	input  wire logic [2:0] i_sel,
	input  wire logic       i_ext_rise,
	input  wire logic       i_ext_fall,
	input  wire logic       i_otl_rise,
	input  wire logic       i_otl_fall,
	output logic            o_trig
);
	logic rise;
	logic fall;

	// Bit 2 picks latch over external input; x00 gives no trigger at all
	always_comb begin
		rise   = i_sel[2] ? i_otl_rise : i_ext_rise;
		fall   = i_sel[2] ? i_otl_fall : i_ext_fall;
		o_trig = (i_sel[0] & rise) | (i_sel[1] & fall); // [R03]
	end
endmodule

//--- core/atp_prescaler.sv
// Free-running prescaler giving one tick per 8, 16 ... 1024 timer clocks
`timescale 1ns/1ps
`include "atp_consts.svh"
module atp_prescaler (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_reset_n,
	output logic [`ATP_PRE_STEPS-1:0]      o_tick
);
	logic [`ATP_PRE_W-1:0] pre_q;
	logic [`ATP_PRE_W-1:0] pre_d;

	always_comb begin
		pre_d = pre_q + `ATP_PRE_W'(1);
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_d;
		end
	end

	for (genvar k = 0; k < `ATP_PRE_STEPS; k++) begin : g_tick
		assign o_tick[k] = &pre_q[k+`ATP_PRE_BASE-1:0];
	end
endmodule

//--- core/atp_aux_timer_pair.sv
// Two auxiliary 16-bit timers chained to and reloading an outside core timer
// Contract
// R01: Each aux timer runs by its run bit, or core run bit when remote set.
// R02: Timer and gated modes count like the core; no output, no toggle latch.
// R03: Input select x00 off, 001-011 external edges, 101-111 latch edges.
// R04: Only overflow-caused latch changes count or reload; software writes never.
// R05: External count input level holds at least 4 clocks; rate max clock/8.
// R06: Timer A in counter mode counts only on overflow-caused latch changes.
// R07: Both latch edges selected: advance every core overflow, 32-bit chain.
// R08: Single latch edge selected: advance every second overflow, 33-bit chain.
// R09: Chained timers keep their own count directions independently.
// R10: Mode 100 copies the aux value into the core timer on each trigger.
// R11: A timer in reload mode never counts, whatever its run bit.
// R12: Each reload sets the irq flag of the timer that supplied the value.
// R13: Latch-triggered reload also raises the core irq flag.
// R14: Timer A reloads only on the core overflow signal.
// R15: Toggle latch reaches the core output line only with output enable 1.
// R16: Same reload trigger on both: timer A ignored, core loaded from timer B.
// R17: Both control registers share one layout, common bits in common places.
// R18: Gated mode counts only while run bit is 1 and gate active.
// R19: Gated 010 counts on low gate level, 011 on high gate level.
// R20: Each counter event steps the 16-bit count by one, wrapping at limits.
`timescale 1ns/1ps
`include "atp_consts.svh"
module atp_aux_timer_pair (
	input  wire logic                     i_core_clk,
	input  wire logic                     i_reset_n,
	input  wire logic [`ATP_ADDR_W-1:0]   i_addr,
	input  wire logic [`ATP_DATA_W-1:0]   i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [`ATP_DATA_W-1:0]   o_rdata,
	input  wire logic                     i_aux_b_count_input,
	input  wire logic                     i_aux_a_direction_input,
	input  wire logic                     i_core_run_bit,
	input  wire logic                     i_core_toggle_latch,
	input  wire logic                     i_core_overflow_signal,
	input  wire logic                     i_core_output_enable,
	output logic                          o_core_output_line,
	output logic                          o_core_reload,
	output logic      [`ATP_DATA_W-1:0]   o_core_reload_value,
	output logic                          o_core_irq_set,
	output logic                          o_aux_a_irq_flag,
	output logic                          o_aux_b_irq_flag
);
	logic [`ATP_CTL_W-1:0]   ctl_q [2];
	logic [`ATP_CTL_W-1:0]   ctl_d [2];
	logic [`ATP_DATA_W-1:0]  cnt_q [2];
	logic [`ATP_DATA_W-1:0]  cnt_d [2];
	logic [1:0]              irq_q;
	logic [1:0]              irq_d;
	logic [1:0]              trig;
	logic [1:0]              rl_trig;
	logic [1:0]              rl_fire;
	logic [1:0]              step;
	logic [1:0]              ext_lvl;
	logic [1:0]              dir_in;
	logic [`ATP_PRE_STEPS-1:0] tick;
	logic                    ext_prev_q;
	logic                    ext_prev_d;
	logic                    ext_rise;
	logic                    ext_fall;
	logic                    otl_rise;
	logic                    otl_fall;
	logic                    wr_status;
	logic [`ATP_DATA_W-1:0]  rdata_d;
	logic                    out_line_d;
	logic                    reload_d;
	logic [`ATP_DATA_W-1:0]  reload_val_d;
	logic                    core_irq_d;

	atp_prescaler u_pre (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.o_tick     (tick)
	);

	// Timer A has no count input of its own, so its external edges never occur
	assign ext_lvl = {i_aux_b_count_input, 1'b0}; // [R06] [R14]
	assign dir_in  = {1'b0, i_aux_a_direction_input};

	// Input is taken as synchronous; the source keeps levels 4 clocks or more
	always_comb begin
		ext_prev_d = i_aux_b_count_input;
		ext_rise   = i_aux_b_count_input & ~ext_prev_q; // [R05]
		ext_fall   = ~i_aux_b_count_input & ext_prev_q;
		// Latch edges come only from the overflow pulse, so software writes
		// to the latch outside are invisible here
		otl_rise   = i_core_overflow_signal & ~i_core_toggle_latch; // [R04]
		otl_fall   = i_core_overflow_signal & i_core_toggle_latch;
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_prev_d;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_aux
		logic [2:0] sel;
		logic       run;
		logic       down;
		logic       gate_on;
		logic       own_ext_rise;
		logic       own_ext_fall;
		logic       wr_ctl;
		logic       wr_cnt;

		assign own_ext_rise = (i == 1) ? ext_rise : 1'b0;
		assign own_ext_fall = (i == 1) ? ext_fall : 1'b0;

		atp_trig_sel u_sel (
			.i_sel      (sel),
			.i_ext_rise (own_ext_rise),
			.i_ext_fall (own_ext_fall),
			.i_otl_rise (otl_rise),
			.i_otl_fall (otl_fall),
			.o_trig     (trig[i])
		);

		always_comb begin
			// Same field positions in both control registers
			sel     = ctl_q[i][`ATP_CTL_SEL_MSB:`ATP_CTL_SEL_LSB]; // [R17]
			run     = ctl_q[i][`ATP_CTL_RC] ? i_core_run_bit
			                                : ctl_q[i][`ATP_CTL_RUN]; // [R01]
			// Direction is private to each timer, also when chained
			down    = ctl_q[i][`ATP_CTL_UD] ^ (ctl_q[i][`ATP_CTL_UDE] & dir_in[i]); // [R09]
			wr_ctl  = i_wr & (i_addr == ((i == 0) ? `ATP_ADDR_CTL_A : `ATP_ADDR_CTL_B));
			wr_cnt  = i_wr & (i_addr == ((i == 0) ? `ATP_ADDR_CNT_A : `ATP_ADDR_CNT_B));
			gate_on = 1'b0;
			step[i] = 1'b0;
			rl_trig[i] = 1'b0;
			unique case (ctl_q[i][`ATP_CTL_MODE_MSB:`ATP_CTL_MODE_LSB])
				atp_pkg::ATP_MODE_TIMER: begin
					step[i] = run & tick[sel]; // [R02]
				end
				atp_pkg::ATP_MODE_GATE_LOW: begin
					gate_on = ~ext_lvl[i]; // [R19]
					step[i] = run & gate_on & tick[sel]; // [R18]
				end
				atp_pkg::ATP_MODE_GATE_HI: begin
					gate_on = ext_lvl[i]; // [R19]
					step[i] = run & gate_on & tick[sel]; // [R18]
				end
				atp_pkg::ATP_MODE_COUNTER: begin
					step[i] = run & trig[i]; // [R07] [R08]
				end
				atp_pkg::ATP_MODE_RELOAD: begin
					// The count holds still here whatever the run bit says
					rl_trig[i] = trig[i]; // [R10] [R11]
				end
				default: begin
					// Reserved codes 101 to 111 leave the timer stopped
					step[i] = 1'b0;
				end
			endcase
			ctl_d[i] = wr_ctl ? i_wdata[`ATP_CTL_W-1:0] : ctl_q[i];
			if (wr_cnt) begin
				cnt_d[i] = i_wdata;
			end else if (step[i]) begin
				cnt_d[i] = down ? cnt_q[i] - `ATP_DATA_W'(1)
				                : cnt_q[i] + `ATP_DATA_W'(1); // [R20]
			end else begin
				cnt_d[i] = cnt_q[i];
			end
		end

		always_ff @(posedge i_core_clk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				ctl_q[i] <= `ATP_CTL_RESET;
				cnt_q[i] <= `ATP_CNT_RESET;
			end else begin
				ctl_q[i] <= ctl_d[i];
				cnt_q[i] <= cnt_d[i];
			end
		end
	end

	always_comb begin
		// On a shared trigger timer B wins and timer A is simply dropped
		rl_fire[1]   = rl_trig[1];
		rl_fire[0]   = rl_trig[0] & ~rl_trig[1]; // [R16]
		reload_d     = rl_trig[0] | rl_trig[1]; // [R10]
		reload_val_d = rl_trig[1] ? cnt_q[1] : cnt_q[0]; // [R16]
		core_irq_d   = (rl_fire[0] & ctl_q[0][`ATP_CTL_SEL_MSB])
		             | (rl_fire[1] & ctl_q[1][`ATP_CTL_SEL_MSB]); // [R13]
		out_line_d   = i_core_toggle_latch & i_core_output_enable; // [R15]
		wr_status    = i_wr & (i_addr == `ATP_ADDR_STATUS);
		// Write one to clear; a reload in the same cycle keeps its flag
		irq_d        = (irq_q & ~({2{wr_status}} & i_wdata[1:0])) | rl_fire; // [R12]
		rdata_d      = '0;
		if (i_rd) begin
			unique case (i_addr)
				`ATP_ADDR_CTL_A:  rdata_d = `ATP_DATA_W'(ctl_q[0]);
				`ATP_ADDR_CTL_B:  rdata_d = `ATP_DATA_W'(ctl_q[1]);
				`ATP_ADDR_CNT_A:  rdata_d = cnt_q[0];
				`ATP_ADDR_CNT_B:  rdata_d = cnt_q[1];
				`ATP_ADDR_STATUS: rdata_d = {14'h0000, irq_q};
				default:          rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_q               <= 2'h0;
			o_rdata             <= '0;
			o_core_output_line  <= 1'b0;
			o_core_reload       <= 1'b0;
			o_core_reload_value <= '0;
			o_core_irq_set      <= 1'b0;
		end else begin
			irq_q               <= irq_d;
			o_rdata             <= rdata_d;
			o_core_output_line  <= out_line_d;
			o_core_reload       <= reload_d;
			o_core_reload_value <= reload_val_d;
			o_core_irq_set      <= core_irq_d;
		end
	end

	assign o_aux_a_irq_flag = irq_q[0];
	assign o_aux_b_irq_flag = irq_q[1];

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_reload_holds: assert property ( // [R11]
		(ctl_q[0][5:3] == 3'h4) && !(i_wr && i_addr == 4'h2) |=> $stable(cnt_q[0]))
		else $error("timer A counted in reload mode");

	a_stop_no_run: assert property ( // [R01]
		(ctl_q[1][5:3] == 3'h1) && !ctl_q[1][9] && !ctl_q[1][6]
		&& !(i_wr && i_addr == 4'h3) |=> $stable(cnt_q[1]))
		else $error("timer B counted with run bit clear");

	a_chain_every_ovf: assert property ( // [R07]
		(ctl_q[1][5:0] == 6'b001111) && ctl_q[1][6] && !ctl_q[1][9]
		&& !ctl_q[1][7] && !ctl_q[1][8] && i_core_overflow_signal
		&& !(i_wr && i_addr == 4'h3) |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
		else $error("32-bit chain missed an overflow");

	a_chain_half_ovf: assert property ( // [R08]
		(ctl_q[0][5:0] == 6'b001101) && i_core_overflow_signal && i_core_toggle_latch
		&& !(i_wr && i_addr == 4'h2) |=> $stable(cnt_q[0]))
		else $error("33-bit chain counted on the wrong edge");

	a_shared_trig_b: assert property ( // [R16]
		rl_trig[0] && rl_trig[1] |=> o_core_reload && o_core_reload_value == $past(cnt_q[1])
		&& !(o_aux_a_irq_flag && !$past(irq_q[0])))
		else $error("shared reload trigger not taken from timer B");

	a_reload_sets_irq: assert property ( // [R12]
		rl_trig[1] |=> o_aux_b_irq_flag ##0 o_core_reload)
		else $error("reload did not set the supplier flag");

	a_otl_core_irq: assert property ( // [R13]
		o_core_reload && !$past(rl_trig[0] & ~rl_trig[1] & ~ctl_q[0][2])
		&& !$past(rl_trig[1] & ~ctl_q[1][2]) |-> o_core_irq_set)
		else $error("latch reload missed the core irq");

	a_output_gated: assert property ( // [R15]
		!i_core_output_enable |=> !o_core_output_line)
		else $error("output line driven without enable");

	a_gate_blocks: assert property ( // [R18]
		(ctl_q[1][5:3] == 3'h3) && !i_aux_b_count_input
		&& !(i_wr && i_addr == 4'h3) |=> $stable(cnt_q[1]))
		else $error("gated timer counted with gate inactive");

	a_read_one_cycle: assert property (
		!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside the answer cycle");

	a_reload_a_src: assert property ( // [R10]
		rl_trig[0] && !rl_trig[1] |=> o_core_reload && o_aux_a_irq_flag
		&& o_core_reload_value == $past(cnt_q[0]))
		else $error("reload from timer A went wrong");

	a_flag_sticky: assert property ( // [R12]
		irq_q[0] && !(i_wr && i_addr == 4'h4 && i_wdata[0]) |=> irq_q[0])
		else $error("timer A flag lost without a clear");

	a_timer_a_deaf: assert property ( // [R06]
		(ctl_q[0][5:3] == 3'h1) && !i_core_overflow_signal
		&& !(i_wr && i_addr == 4'h2) |=> $stable(cnt_q[0]))
		else $error("timer A counted without an overflow");

	a_ext_rise_step: assert property ( // [R03]
		(ctl_q[1][9:0] == 10'h049) && i_aux_b_count_input && !$past(i_aux_b_count_input)
		&& !(i_wr && i_addr == 4'h3) |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
		else $error("timer B missed a rising input edge");

	a_no_sw_reload: assert property ( // [R04]
		!i_core_overflow_signal && $stable(i_aux_b_count_input)
		|=> !o_core_reload && !o_core_irq_set)
		else $error("reload without an overflow or input edge");

	a_out_follows: assert property ( // [R15]
		i_core_output_enable |=> o_core_output_line == $past(i_core_toggle_latch))
		else $error("output line does not follow the latch");
endmodule

//--- testbench/atp_core_model.sv
// Partner model of the core timer link and the external count source
`timescale 1ns/1ps
module atp_core_model (
	input  wire logic i_core_clk,
	input  wire logic i_reset_n,
	input  wire logic i_ovf_req,
	input  wire logic i_sw_flip,
	input  wire logic i_ext_req,
	output logic      o_latch,
	output logic      o_ovf,
	output logic      o_ext
);
	logic [1:0] hold_q;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_latch <= 1'b0;
			o_ovf   <= 1'b0;
			o_ext   <= 1'b0;
			hold_q  <= 2'h0;
		end else begin
			o_ovf <= i_ovf_req;
			// Flips at the edge that takes the pulse, so the block sees the old level
			if (o_ovf || i_sw_flip) begin
				o_latch <= !o_latch;
			end
			// A level stands four clocks before it may change again
			if (hold_q != 2'h0) begin
				hold_q <= hold_q - 2'h1;
			end else if (i_ext_req) begin
				o_ext  <= !o_ext;
				hold_q <= 2'h3;
			end
		end
	end
endmodule

//--- testbench/tb_auxiliary_timer_pair.sv
// Self-checking bench for the auxiliary timer pair
`timescale 1ns/1ps
module tb_auxiliary_timer_pair;
	logic        clk, rst_n, wr, rd, ovf_req, sw_flip, ext_req, core_run, oe, dir;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, rval, v;
	logic        lat_w, ovf_w, ext_w, out_line, reload, irq_set, fa, fb;
	int          errors, checks, seed, cyc, lat, ext, flag;
	int          ctl[2], cnt[2];

	atp_aux_timer_pair DUT (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_aux_b_count_input(ext_w),
		.i_aux_a_direction_input(dir), .i_core_run_bit(core_run),
		.i_core_toggle_latch(lat_w), .i_core_overflow_signal(ovf_w),
		.i_core_output_enable(oe), .o_core_output_line(out_line),
		.o_core_reload(reload), .o_core_reload_value(rval), .o_core_irq_set(irq_set),
		.o_aux_a_irq_flag(fa), .o_aux_b_irq_flag(fb));
	atp_core_model core (
		.i_core_clk(clk), .i_reset_n(rst_n), .i_ovf_req(ovf_req), .i_sw_flip(sw_flip),
		.i_ext_req(ext_req), .o_latch(lat_w), .o_ovf(ovf_w), .o_ext(ext_w));

	initial begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		if (a < 2) ctl[a] = d & 16'h03FF;
		else if (a < 4) cnt[a-2] = d;
		else if (a == 4) flag &= ~d;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// One overflow, software flip or external edge, then the reference model
	task automatic ev(input int o, input int s, input int x);
		int r, f, t, m, rl;
		rl = -1;
		@(posedge clk);
		ovf_req <= o[0];
		sw_flip <= s[0];
		ext_req <= x[0];
		@(posedge clk);
		ovf_req <= 1'b0;
		sw_flip <= 1'b0;
		ext_req <= 1'b0;
		@(posedge clk);
		#1;
		for (int i = 0; i < 2; i++) begin
			// Timer A has no external input, so only latch edges reach it
			r = ctl[i][2] ? o & !lat : i & x & !ext;
			f = ctl[i][2] ? o & lat : i & x & ext;
			t = ctl[i][0] & r | ctl[i][1] & f;
			m = ctl[i][5:3];
			if (t && m == 1 && (ctl[i][9] ? core_run : ctl[i][6]))
				cnt[i] = (cnt[i] + ((ctl[i][7] ^ (ctl[i][8] & dir & (i == 0))) ? 65535 : 1))
				         & 65535;
			if (t && m == 4)
				rl = i;
		end
		if (rl >= 0) begin
			flag |= 1 << rl;
			chk(rval, cnt[rl]);
			chk(irq_set, ctl[rl][2]);
		end else
			chk(irq_set, 0);
		chk(reload, rl >= 0);
		chk({fb, fa}, flag);
		lat ^= o | s;
		ext ^= x;
		repeat (2) @(posedge clk);
		#1 chk(out_line, lat & oe);
	endtask
	// Both timers run on the core run bit for exactly 64 clocks: 4 ticks at /16, 8 at /8
	task automatic tm(input int ma, input int mb);
		@(posedge clk);
		core_run <= 1'b0;
		wr_reg(0, 16'h0201 | ma << 3);
		wr_reg(1, 16'h0200 | mb << 3);
		@(posedge clk);
		core_run <= 1'b1;
		repeat (64) @(posedge clk);
		core_run <= 1'b0;
		// Timer A gate always sees a low level, timer B gate sees the input level
		if (ma == 0 || ma == 2)
			cnt[0] = (cnt[0] + 4) & 65535;
		if (mb == 0 || mb == 2 + ext)
			cnt[1] = (cnt[1] + 8) & 65535;
		rd_reg(2, cnt[0]);
		rd_reg(3, cnt[1]);
	endtask

	initial begin
		seed = 28444;
		rst_n = 1'b0;
		{wr, rd, ovf_req, sw_flip, ext_req, core_run, oe, dir} = 8'h00;
		addr = 4'h0;
		wdata = 16'h0000;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 6; a++) rd_reg(a, 0);
		// Run bit kept clear so the random layout cannot start a timer
		v = 16'($random(seed)) & 16'h03BF;
		wr_reg(0, v);
		wr_reg(1, v);
		wr_reg(9, v);
		rd_reg(0, v);
		rd_reg(1, v);
		rd_reg(9, 0);
		$display("test registers done");
		wr_reg(3, 16'($random(seed)));
		for (int s = 0; s < 4; s++) begin
			wr_reg(0, s | 16'h0048);
			wr_reg(1, s | 16'h0048 | (s == 2) << 7);
			repeat (3) ev(0, 0, 1);
			rd_reg(2, cnt[0]);
			rd_reg(3, cnt[1]);
		end
		$display("test external count done");
		wr_reg(2, 16'h0000);
		dir <= 1'b1;
		for (int s = 4; s < 8; s++) begin
			// Direction input high with its enable set flips the direction bit
			wr_reg(0, s | 16'h0148 | (s & 1) << 7);
			wr_reg(1, 16'h004F);
			repeat (3) ev(1, 0, 0);
			ev(0, 1, 0);
			rd_reg(2, cnt[0]);
			rd_reg(3, cnt[1]);
		end
		$display("test chaining done");
		wr_reg(0, 16'h020F);
		for (int r = 0; r < 2; r++) begin
			@(posedge clk);
			core_run <= r[0];
			repeat (2) ev(1, 0, 0);
			rd_reg(2, cnt[0]);
		end
		$display("test remote run done");
		@(posedge clk);
		oe <= 1'b1;
		wr_reg(2, 16'($random(seed)));
		wr_reg(3, 16'($random(seed)));
		wr_reg(0, 16'h0065);
		wr_reg(1, 16'h0066);
		repeat (4) ev(1, 0, 0);
		ev(0, 1, 0);
		wr_reg(4, 16'h0003);
		wr_reg(0, 16'h0067);
		wr_reg(1, 16'h0067);
		ev(1, 0, 0);
		wr_reg(1, 16'h0061);
		repeat (2) ev(0, 0, 1);
		rd_reg(4, flag);
		rd_reg(2, cnt[0]);
		rd_reg(3, cnt[1]);
		$display("test reload done");
		tm(2, 3);
		ev(0, 0, 1);
		tm(0, 3);
		$display("test timer modes done");
		report_and_stop();
	end
endmodule
